// ===== src/operand_address_generator.sv
// operand address generator with programmer-visible register set
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  input wire logic [operand_address_pkg::BYTE_W-1:0] opcode,
  input wire logic byte_valid,
  input wire logic [operand_address_pkg::BYTE_W-1:0] mem_byte,
  input wire operand_address_pkg::reg_cmd_s reg_cmd,
  input wire logic arith_overflow,
  input wire logic compare_event,
  input wire logic jump_tests_ovf,
  output logic [operand_address_pkg::ADDR_W-1:0] fetch_address,
  output logic fetch_request,
  output logic busy,
  output logic done,
  output logic [operand_address_pkg::WORD_W-1:0] operand_address,
  output logic [2:0] operand_bytes,
  output logic variable_length,
  output logic type_select,
  output logic index_equals_main,
  output var operand_address_pkg::prog_regs_s prog_regs
);
  import operand_address_pkg::*;

  typedef struct packed {
    phase_e phase;
    prog_regs_s regs;
    work_regs_s work;
    logic [BYTE_W-1:0] hold_byte;
    logic [ADDR_W-1:0] fetch_ptr;
    logic [2:0] lit_left;
    logic second_level;
    logic done;
  } state_s;

  state_s cur, next_cur;

  // add index when the address word flag is set, wrap to 15 bits
  function automatic logic [ADDR_W-1:0] resolve(input logic [WORD_W-1:0] word,
                                                input logic [WORD_W-1:0] idx);
    logic [WORD_W-1:0] sum;
    sum = word[INDEX_FLAG_BIT] ? (word + idx) : word;
    return sum[ADDR_W-1:0];
  endfunction

  // sign-extended byte plus program counter, wrapped
  function automatic logic [ADDR_W-1:0] rel(input logic [BYTE_W-1:0] y,
                                            input logic [ADDR_W-1:0] pc);
    logic [ADDR_W-1:0] ext;
    ext = {{(ADDR_W-BYTE_W){y[SIGN_BIT]}}, y};
    return ADDR_W'(ext + pc);
  endfunction

  // operand byte count: selector value plus one, or fixed two
  function automatic logic [2:0] byte_count(input logic varlen, input logic [1:0] wl);
    return varlen ? (3'({1'b0, wl}) + 3'h1) : 3'h2;
  endfunction

  logic [4:0] op_field;
  logic [2:0] mode;
  logic is_jump;
  assign op_field = cur.work.instruction[BYTE_W-1:OPCODE_LSB];
  assign mode = cur.work.instruction[OPCODE_LSB-1:MODE_LSB];
  assign is_jump = (op_field == OP_JUMP) || (op_field == OP_RJUMP);

  // next-state computation
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    // register commands from the execute side
    if (reg_cmd.load_main) begin
      next_cur.regs.main_accumulator = reg_cmd.value;
    end
    if (reg_cmd.load_aux) begin
      next_cur.regs.auxiliary_accumulator = reg_cmd.value;
    end
    if (reg_cmd.load_index) begin
      next_cur.regs.index_register = reg_cmd.value;
    end else if (reg_cmd.inc_index) begin
      next_cur.regs.index_register = cur.regs.index_register + 16'h0001;
    end
    if (reg_cmd.load_pc) begin
      next_cur.regs.program_counter = reg_cmd.value[ADDR_W-1:0];
    end
    if (reg_cmd.load_wlen) begin
      next_cur.regs.word_length_selector = reg_cmd.value[1:0];
    end
    // set wins over clear when both arrive together
    if (arith_overflow || compare_event || reg_cmd.set_ovf) begin
      next_cur.regs.overflow_flag = 1'b1;
    end else if (reg_cmd.clr_ovf || jump_tests_ovf) begin
      next_cur.regs.overflow_flag = 1'b0;
    end
    case (cur.phase)
      ST_IDLE: begin
        if (start) begin
          next_cur.work.instruction = opcode;
          next_cur.second_level = 1'b0;
          next_cur.fetch_ptr = cur.regs.program_counter;
          case (opcode[OPCODE_LSB-1:MODE_LSB])
            M_INDEXED: begin
              next_cur.work.operand_address = {1'b0, cur.regs.index_register[ADDR_W-1:0]};
              next_cur.phase = ST_DONE;
            end
            M_LIT: begin
              if ((opcode[BYTE_W-1:OPCODE_LSB] == OP_JUMP) || (opcode[BYTE_W-1:OPCODE_LSB] == OP_RJUMP)) begin
                next_cur.phase = ST_BYTE2;
              end else begin
                next_cur.work.operand_address = {1'b0, cur.regs.program_counter};
                next_cur.lit_left = byte_count(opcode[VARLEN_BIT], cur.regs.word_length_selector);
                next_cur.phase = ST_LIT;
              end
            end
            default: begin
              next_cur.phase = ST_BYTE2;
            end
          endcase
        end
      end
      ST_BYTE2: begin
        if (byte_valid) begin
          // counter moves past each instruction byte taken
          next_cur.regs.program_counter = ADDR_W'(cur.regs.program_counter + ADDR_ONE);
          next_cur.hold_byte = mem_byte;
          case (mode)
            M_DIRECT: begin
              next_cur.work.operand_address = {8'h00, mem_byte};
              next_cur.phase = ST_DONE;
            end
            M_REL: begin
              next_cur.work.operand_address =
                {1'b0, rel(mem_byte, ADDR_W'(cur.regs.program_counter + ADDR_ONE))};
              next_cur.phase = ST_DONE;
            end
            M_IND0: begin
              next_cur.fetch_ptr = {7'h00, mem_byte};
              next_cur.phase = ST_PTR_HI;
            end
            M_INDREL: begin
              next_cur.fetch_ptr = rel(mem_byte, ADDR_W'(cur.regs.program_counter + ADDR_ONE));
              next_cur.phase = ST_PTR_HI;
            end
            M_BIAS: begin
              next_cur.work.operand_address =
                {1'b0, ADDR_W'(cur.regs.index_register + {8'h00, mem_byte})};
              next_cur.phase = ST_DONE;
            end
            default: begin
              next_cur.phase = ST_BYTE3; // modes 6 and jump 7
            end
          endcase
        end
      end
      ST_BYTE3: begin
        if (byte_valid) begin
          next_cur.regs.program_counter = ADDR_W'(cur.regs.program_counter + ADDR_ONE);
          if (mode == M_EXT) begin
            next_cur.work.operand_address =
              {1'b0, resolve({cur.hold_byte, mem_byte}, cur.regs.index_register)};
            next_cur.phase = ST_DONE;
          end else begin
            next_cur.fetch_ptr = resolve({cur.hold_byte, mem_byte}, cur.regs.index_register);
            next_cur.second_level = 1'b1;
            next_cur.phase = ST_PTR_HI;
          end
        end
      end
      ST_PTR_HI: begin
        if (byte_valid) begin
          next_cur.hold_byte = mem_byte; // first byte carries the index flag in bit 7
          next_cur.fetch_ptr = ADDR_W'(cur.fetch_ptr + ADDR_ONE);
          next_cur.phase = ST_PTR_LO;
        end
      end
      ST_PTR_LO: begin
        if (byte_valid) begin
          next_cur.work.operand_address =
            {1'b0, resolve({cur.hold_byte, mem_byte}, cur.regs.index_register)};
          next_cur.phase = ST_DONE;
        end
      end
      ST_LIT: begin
        // literal bytes are consumed by the execute side; count them off here
        if (byte_valid) begin
          next_cur.regs.program_counter = ADDR_W'(cur.regs.program_counter + ADDR_ONE);
          next_cur.lit_left = cur.lit_left - 3'h1;
          if (cur.lit_left == 3'h1) begin
            next_cur.phase = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        next_cur.done = 1'b1;
        next_cur.phase = ST_IDLE;
      end
      default: begin
        next_cur.phase = ST_IDLE;
      end
    endcase
  end

  // one register stage for the whole state
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur.phase <= ST_IDLE;
      cur.regs <= '{WORD_RESET, WORD_RESET, WORD_RESET, PC_RESET, WLEN_RESET, 1'b0};
      cur.work <= '0;
      cur.hold_byte <= '0;
      cur.fetch_ptr <= PC_RESET;
      cur.lit_left <= 3'h0;
      cur.second_level <= 1'b0;
      cur.done <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // fetch address points at the instruction stream or at the indirect word
  assign fetch_request = (cur.phase == ST_BYTE2) || (cur.phase == ST_BYTE3) ||
                         (cur.phase == ST_PTR_HI) || (cur.phase == ST_PTR_LO) || (cur.phase == ST_LIT);
  assign fetch_address = ((cur.phase == ST_PTR_HI) || (cur.phase == ST_PTR_LO)) ?
                         cur.fetch_ptr : cur.regs.program_counter;
  assign busy = (cur.phase != ST_IDLE);
  assign done = cur.done;
  assign operand_address = cur.work.operand_address;
  assign variable_length = cur.work.instruction[VARLEN_BIT];
  assign type_select = cur.work.instruction[VARLEN_BIT];
  assign operand_bytes = byte_count(cur.work.instruction[VARLEN_BIT], cur.regs.word_length_selector);
  assign index_equals_main = (cur.regs.index_register == cur.regs.main_accumulator);
  assign prog_regs = cur.regs;

  // assertions
  direct_mode_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE2 && byte_valid && mode == M_DIRECT) |=> (operand_address == {8'h00, $past(mem_byte)}))
    else $error("direct page address wrong");
  indexed_mode_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_IDLE && start && opcode[2:0] == M_INDEXED && !reg_cmd.load_index && !reg_cmd.inc_index)
      |=> (operand_address == {1'b0, prog_regs.index_register[ADDR_W-1:0]}) ##1 done)
    else $error("indexed mode address wrong");
  ovf_set_a: assert property (@(posedge clock) disable iff (reset)
    (arith_overflow || compare_event) |=> prog_regs.overflow_flag)
    else $error("overflow not set");
  ovf_clr_a: assert property (@(posedge clock) disable iff (reset)
    (jump_tests_ovf && !arith_overflow && !compare_event && !reg_cmd.set_ovf) |=> !prog_regs.overflow_flag)
    else $error("overflow not cleared");
  wlen_hold_a: assert property (@(posedge clock) disable iff (reset)
    !reg_cmd.load_wlen |=> $stable(prog_regs.word_length_selector))
    else $error("word length changed without control");
  addr_wrap_a: assert property (@(posedge clock) disable iff (reset)
    operand_address[INDEX_FLAG_BIT] == 1'b0)
    else $error("operand address exceeds 15 bits");
  done_pulse_a: assert property (@(posedge clock) disable iff (reset)
    done |=> !done)
    else $error("done longer than one cycle");
  bias_mode_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE2 && byte_valid && mode == M_BIAS && !reg_cmd.load_index && !reg_cmd.inc_index)
      |=> (operand_address[14:0] == 15'($past(prog_regs.index_register) + $past(mem_byte))))
    else $error("bias mode address wrong");

  // check-side copies of an address word and of a relative pointer, worked out apart
  // from the functions above so that the properties below do not grade themselves
  logic [WORD_W-1:0] byte_pair;
  logic [ADDR_W-1:0] pair_target;
  logic [ADDR_W-1:0] sign_byte;
  logic [ADDR_W-1:0] rel_target;
  assign byte_pair = {cur.hold_byte, mem_byte};
  assign pair_target = byte_pair[INDEX_FLAG_BIT] ?
                       ADDR_W'(byte_pair + cur.regs.index_register) : byte_pair[ADDR_W-1:0];
  assign sign_byte = {{(ADDR_W-BYTE_W){mem_byte[SIGN_BIT]}}, mem_byte};
  assign rel_target = ADDR_W'(cur.regs.program_counter + ADDR_ONE + sign_byte);

  // relative operand: the byte is signed and counts from the location after it
  rel_mode_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE2 && byte_valid && mode == M_REL) |=> (operand_address == {1'b0, $past(rel_target)}))
    else $error("relative address wrong");

  // page zero pointer: the indirect word can only sit in the first 256 locations
  ind0_ptr_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE2 && byte_valid && mode == M_IND0)
      |=> (fetch_request && fetch_address == {7'h00, $past(mem_byte)}))
    else $error("page zero pointer wrong");

  // relative pointer to the indirect word
  indrel_ptr_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE3 - ST_BYTE3 + ST_BYTE2 && byte_valid && mode == M_INDREL)
      |=> (fetch_request && fetch_address == $past(rel_target)))
    else $error("relative pointer wrong");

  // the low byte of an address word sits one location above its high byte
  ptr_step_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_PTR_HI && byte_valid) |=> (fetch_address == ADDR_W'($past(fetch_address) + ADDR_ONE)))
    else $error("indirect word bytes out of order");

  // extended address word from the instruction stream, indexed when flagged
  ext_mode_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE3 && byte_valid && mode == M_EXT) |=> (operand_address == {1'b0, $past(pair_target)}))
    else $error("extended address wrong");

  // an indirect word ends every indirect mode; done follows one cycle later
  ind_word_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_PTR_LO && byte_valid) |=> (operand_address == {1'b0, $past(pair_target)}) ##1 done)
    else $error("indirect address wrong");

  // a jump goes one level deeper: the extended word only points at the target word
  jump_ptr_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_BYTE3 && byte_valid && mode != M_EXT)
      |=> (cur.second_level && is_jump && fetch_address == $past(pair_target)))
    else $error("jump pointer wrong");

  // literal data sits at the counter, so the counter itself is the operand address
  lit_addr_a: assert property (@(posedge clock) disable iff (reset)
    (cur.phase == ST_IDLE && start && opcode[OPCODE_LSB-1:MODE_LSB] == M_LIT
      && opcode[BYTE_W-1:OPCODE_LSB] != OP_JUMP && opcode[BYTE_W-1:OPCODE_LSB] != OP_RJUMP)
      |=> (operand_address == {1'b0, $past(prog_regs.program_counter)}))
    else $error("literal address wrong");

  // every instruction or literal byte taken moves the counter on by one
  pc_step_a: assert property (@(posedge clock) disable iff (reset)
    (fetch_request && byte_valid && cur.phase != ST_PTR_HI && cur.phase != ST_PTR_LO && !reg_cmd.load_pc)
      |=> (prog_regs.program_counter == ADDR_W'($past(prog_regs.program_counter) + ADDR_ONE)))
    else $error("program counter step wrong");

  // indirect words are not part of the instruction, so they leave the counter alone
  pc_ptr_hold_a: assert property (@(posedge clock) disable iff (reset)
    ((cur.phase == ST_PTR_HI || cur.phase == ST_PTR_LO) && !reg_cmd.load_pc) |=> $stable(prog_regs.program_counter))
    else $error("program counter moved on indirect word");

  // increment of the index register wraps at 16 bits
  inc_index_a: assert property (@(posedge clock) disable iff (reset)
    (reg_cmd.inc_index && !reg_cmd.load_index) |=> (prog_regs.index_register == $past(prog_regs.index_register) + 16'h0001))
    else $error("index increment wrong");

  // main accumulator load
  load_main_a: assert property (@(posedge clock) disable iff (reset)
    reg_cmd.load_main |=> (prog_regs.main_accumulator == $past(reg_cmd.value)))
    else $error("main accumulator load wrong");

  // word length load by the control instruction
  wlen_load_a: assert property (@(posedge clock) disable iff (reset)
    reg_cmd.load_wlen |=> (prog_regs.word_length_selector == $past(reg_cmd.value[1:0])))
    else $error("word length load wrong");

  // a start while busy must not disturb the instruction being worked on
  start_refused_a: assert property (@(posedge clock) disable iff (reset)
    (busy && start) |=> $stable(cur.work.instruction))
    else $error("start accepted while busy");

  // variable length: one to four bytes from the selector
  varlen_count_a: assert property (@(posedge clock) disable iff (reset)
    variable_length |-> (operand_bytes == {1'b0, prog_regs.word_length_selector} + 3'h1))
    else $error("variable byte count wrong");

  // fixed length instructions always move a word
  fixed_count_a: assert property (@(posedge clock) disable iff (reset)
    !variable_length |-> (operand_bytes == 3'h2))
    else $error("fixed byte count wrong");
endmodule
`default_nettype wire

// ===== src/operand_address_pkg.sv
// package: constants and types for the operand address generator
package operand_address_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int INDEX_FLAG_BIT = 15;
  localparam int IND_FLAG_BYTE_BIT = 7;
  localparam int SIGN_BIT = 7;
  localparam int VARLEN_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int OPCODE_LSB = 3;
  // opcode of jump and return jump (upper five bits)
  localparam logic [4:0] OP_JUMP = 5'h0C;
  localparam logic [4:0] OP_RJUMP = 5'h0D;
  localparam logic [2:0] M_DIRECT = 3'h0;
  localparam logic [2:0] M_REL = 3'h1;
  localparam logic [2:0] M_IND0 = 3'h2;
  localparam logic [2:0] M_INDREL = 3'h3;
  localparam logic [2:0] M_INDEXED = 3'h4;
  localparam logic [2:0] M_BIAS = 3'h5;
  localparam logic [2:0] M_EXT = 3'h6;
  localparam logic [2:0] M_LIT = 3'h7;
  // reset values
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] PC_RESET = 15'h0000;
  localparam logic [1:0] WLEN_RESET = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 15'h0001;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_BYTE2 = 7'h02,
    ST_BYTE3 = 7'h04,
    ST_PTR_HI = 7'h08,
    ST_PTR_LO = 7'h10,
    ST_LIT = 7'h20,
    ST_DONE = 7'h40
  } phase_e;

  // register load/operation command from the execute side
  typedef struct packed {
    logic load_main;
    logic load_aux;
    logic load_index;
    logic inc_index;
    logic load_pc;
    logic load_wlen;
    logic set_ovf;
    logic clr_ovf;
    logic [WORD_W-1:0] value;
  } reg_cmd_s;

  typedef struct packed {
    logic [WORD_W-1:0] main_accumulator;
    logic [WORD_W-1:0] auxiliary_accumulator;
    logic [WORD_W-1:0] index_register;
    logic [ADDR_W-1:0] program_counter;
    logic [1:0] word_length_selector;
    logic overflow_flag;
  } prog_regs_s;

  typedef struct packed {
    logic [BYTE_W-1:0] condition_flags;
    logic [BYTE_W-1:0] instruction;
    logic [WORD_W-1:0] operand_address;
  } work_regs_s;
endpackage

// ===== tb/core_memory_model.sv
// core memory model that answers the byte fetches of the address generator
`timescale 1ns/10ps
`default_nettype none
module core_memory_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic [operand_address_pkg::ADDR_W-1:0] fetch_address,
  input wire logic fetch_request,
  output logic byte_valid,
  output logic [operand_address_pkg::BYTE_W-1:0] mem_byte
);
  logic [7:0] mem [0:32767];
  int delay = 0;
  int wait_count = 0;

  // one pulse per byte, after delay idle cycles; between bytes the data lines carry the
  // inverse of the last byte so that a late sample never sees a plausible stale value
  always @(posedge clock) begin
    #1;
    if (reset || byte_valid || !fetch_request) begin
      if (reset) begin
        mem_byte = 8'h00;
      end else if (byte_valid) begin
        mem_byte = ~mem_byte;
      end
      byte_valid = 1'b0;
      wait_count = 0;
    end else if (wait_count < delay) begin
      wait_count++;
    end else begin
      byte_valid = 1'b1;
      mem_byte = mem[fetch_address];
    end
  end
endmodule
`default_nettype wire

// ===== tb/operand_address_generator_tb.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
`default_nettype none
module operand_address_generator_tb;
  import operand_address_pkg::*;
  logic clock, reset, start, byte_valid, arith_overflow, compare_event, jump_tests_ovf;
  logic fetch_request, busy, done, variable_length, type_select, index_equals_main;
  logic [BYTE_W-1:0] opcode, mem_byte;
  logic [ADDR_W-1:0] fetch_address;
  logic [WORD_W-1:0] operand_address;
  logic [2:0] operand_bytes;
  reg_cmd_s reg_cmd;
  prog_regs_s prog_regs;
  logic [31:0] seed = 32'h00014FF3;
  logic [30:0] expect_q [$];
  logic [1:0] wl = 2'h0;
  int bad_count = 0;
  int comparisons = 0;

  operand_address_generator operand_address_generator_inst (.clock(clock), .reset(reset), .start(start),
    .opcode(opcode), .byte_valid(byte_valid), .mem_byte(mem_byte), .reg_cmd(reg_cmd),
    .arith_overflow(arith_overflow), .compare_event(compare_event), .jump_tests_ovf(jump_tests_ovf),
    .fetch_address(fetch_address), .fetch_request(fetch_request), .busy(busy), .done(done),
    .operand_address(operand_address), .operand_bytes(operand_bytes), .variable_length(variable_length),
    .type_select(type_select), .index_equals_main(index_equals_main), .prog_regs(prog_regs));
  core_memory_model core_memory_model_inst (.clock(clock), .reset(reset), .fetch_address(fetch_address),
    .fetch_request(fetch_request), .byte_valid(byte_valid), .mem_byte(mem_byte));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // address words are stored high byte first
  function automatic logic [15:0] word(input logic [14:0] a);
    return {core_memory_model_inst.mem[a], core_memory_model_inst.mem[a + 15'h0001]};
  endfunction

  // flag in bit 15 adds the index register; the sum wraps at 15 bits
  function automatic logic [14:0] eff(input logic [15:0] w, input logic [15:0] x);
    return w[15] ? w[14:0] + x[14:0] : w[14:0];
  endfunction

  task automatic check(input string name, input logic [65:0] seen, input logic [65:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // flags: main, aux, index, inc, pc, wlen, set, clear from the top bit down
  task automatic put(input logic [7:0] flags, input logic [15:0] v);
    step();
    reg_cmd = {flags, v};
    step();
    reg_cmd = '0;
  endtask

  task automatic pulse_ev(input logic [2:0] ev);
    step();
    {arith_overflow, compare_event, jump_tests_ovf} = ev;
    step();
    {arith_overflow, compare_event, jump_tests_ovf} = 3'h0;
  endtask

  // one address generation; the expectation is queued before the start pulse
  task automatic run(input logic [7:0] op, input logic [14:0] p, input logic [15:0] x, input logic hold);
    logic [7:0] y;
    logic [14:0] ptr;
    logic [14:0] ea;
    logic [15:0] w;
    int n;
    put(8'h08, {1'b0, p});
    put(8'h20, x);
    y = core_memory_model_inst.mem[p];
    w = word(p);
    ptr = p + 15'h0001 + {{7{y[7]}}, y};
    n = 1;
    case (op[2:0])
      M_DIRECT: ea = {7'h00, y};
      M_REL: ea = ptr;
      M_IND0: ea = eff(word({7'h00, y}), x);
      M_INDREL: ea = eff(word(ptr), x);
      M_INDEXED: n = 0;
      M_BIAS: ea = x[14:0] + {7'h00, y};
      M_EXT: n = 2;
      default: n = op[3] ? wl + 1 : 2;
    endcase
    if (op[2:0] == M_INDEXED) ea = x[14:0];
    if (op[2:0] == M_EXT) ea = eff(w, x);
    if (op[2:0] == M_LIT) ea = p;
    if (op[2:0] == M_LIT && (op[7:3] == OP_JUMP || op[7:3] == OP_RJUMP)) begin
      ea = eff(word(eff(w, x)), x);
      n = 2;
    end
    expect_q.push_back({1'b0, ea, p + n[14:0]});
    step();
    opcode = op;
    start = 1'b1;
    step();
    check("busy after start", busy, 1'b1);
    start = hold;
    step();
    start = 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++) step();
    if (n == 300) begin
      bad_count++;
      end_of_test();
    end
    check("idle at done", {busy, fetch_request}, 2'h0);
    check("variable length", variable_length, op[3]);
    check("type select", type_select, op[3]);
    check("operand bytes", operand_bytes, op[3] ? wl + 3'h1 : 3'h2);
    step();
  endtask

  // results are compared where done pulses, against the oldest queued note
  always @(negedge clock) begin
    if (done === 1'b1) begin
      if (expect_q.size() == 0) begin
        check("done without request", 1'b1, 1'b0);
      end else begin
        check("operand address", operand_address, expect_q[0][30:15]);
        check("program counter", prog_regs.program_counter, expect_q[0][14:0]);
        void'(expect_q.pop_front());
      end
    end
  end

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    logic [31:0] r;
    logic [15:0] v;
    {reset, start, arith_overflow, compare_event, jump_tests_ovf} = 5'h10;
    opcode = 8'h00;
    reg_cmd = '0;
    for (int i = 0; i < 32768; i++) begin
      r = rnd();
      core_memory_model_inst.mem[i] = r[7:0];
    end
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    check("registers after reset", prog_regs, '0);
    check("outputs after reset", {busy, done, fetch_request, operand_address}, '0);
    r = rnd();
    v = r[15:0];
    put(8'h80, v);
    put(8'h40, r[31:16]);
    put(8'h20, v);
    check("main accumulator", prog_regs.main_accumulator, v);
    check("auxiliary accumulator", prog_regs.auxiliary_accumulator, r[31:16]);
    check("index equals main", index_equals_main, 1'b1);
    put(8'h10, 16'h0000);
    check("index increment", prog_regs.index_register, v + 16'h0001);
    check("index differs", index_equals_main, 1'b0);
    // overflow: set sources, clear sources, and set winning over clear
    pulse_ev(3'h4);
    check("overflow arith", prog_regs.overflow_flag, 1'b1);
    pulse_ev(3'h1);
    check("overflow jump test", prog_regs.overflow_flag, 1'b0);
    pulse_ev(3'h2);
    check("overflow compare", prog_regs.overflow_flag, 1'b1);
    put(8'h01, 16'h0000);
    check("overflow clear", prog_regs.overflow_flag, 1'b0);
    put(8'h03, 16'h0000);
    check("overflow set and clear", prog_regs.overflow_flag, 1'b1);
    // every mode, random bytes and registers, memory prompt and slow, start held into busy
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      wl = r[1:0];
      put(8'h04, {14'h0000, wl});
      check("word length", prog_regs.word_length_selector, wl);
      core_memory_model_inst.delay = i % 3 * 2;
      v = 16'(rnd());
      if (i % 16 == 15) r[7:3] = (i % 32 == 15) ? OP_JUMP : OP_RJUMP;
      run({r[7:3], i[2:0]}, r[22:8], v, i[3]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
